// ==== src/sasc_top.sv ====
`timescale 1ns/1ps
`include "sasc_regs.svh"

// Notes on behaviour
// - Auxiliary period equals {high byte, low byte} system clock periods.
// - Only the auxiliary channel exists; left and right enables are ignored.
// - Reference code 00 is 1.428V, 01 analog supply, 10 is 1.224V.
// - Results are 14 bits, valid bits left-aligned, low unused bits invalid.
// - Resolution codes 000..101 give 7,9..13 bits; 110 and 111 give 14.
// - Sampling lasts 3,6,9,12,18,24,48 or 144 converter clock periods.
// - Input mode 00 is single-ended; channel field picks the input.
// - Input mode 01 is differential, pin B1 negative, channel field positive.
// - Channel codes map to none, B0, B1, B6, B7, temperature pair, ground, divider.
// - Format bit clear gives unsigned; set inverts result top bit.
// - Manual mode: writing 0x80 to start register begins one conversion.
// - Latest result is readable anytime from low and high byte registers.
// - Done select 01 or 11 means a valid rising edge completes conversion.
// - Status bit zero reads busy while a conversion is in progress.
// - Battery divider 01 routes a third of I/O supply, 10 a third of B7.
module sasc_top
  import sasc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [9:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic [3:0]   wb_sel_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         conv_valid_i,
  input  wire logic [13:0]  conv_data_i,
  output logic              conv_clk_o,
  output logic              sample_o,
  output logic              busy_o,
  output sasc_analog_t      analog_o
);

  sasc_regs_t q;
  sasc_regs_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic [7:0] samp_len(input logic [2:0] code);
    case (code)
      3'h0:    samp_len = `SASC_SAMP_0;
      3'h1:    samp_len = `SASC_SAMP_1;
      3'h2:    samp_len = `SASC_SAMP_2;
      3'h3:    samp_len = `SASC_SAMP_3;
      3'h4:    samp_len = `SASC_SAMP_4;
      3'h5:    samp_len = `SASC_SAMP_5;
      3'h6:    samp_len = `SASC_SAMP_6;
      default: samp_len = `SASC_SAMP_7;
    endcase
  endfunction : samp_len

  function automatic logic [3:0] res_bits(input logic [2:0] code);
    case (code)
      3'h0:    res_bits = 4'h7;
      3'h1:    res_bits = 4'h9;
      3'h2:    res_bits = 4'ha;
      3'h3:    res_bits = 4'hb;
      3'h4:    res_bits = 4'hc;
      3'h5:    res_bits = 4'hd;
      default: res_bits = 4'he;
    endcase
  endfunction : res_bits

  function automatic sasc_ain_t chan_dec(input logic [4:0] code);
    case (code)
      5'h05:   chan_dec = SASC_AIN_B0;
      5'h06:   chan_dec = SASC_AIN_B1;
      5'h0b:   chan_dec = SASC_AIN_B6;
      5'h0c:   chan_dec = SASC_AIN_B7;
      5'h0f:   chan_dec = SASC_AIN_TEMP_N;
      5'h10:   chan_dec = SASC_AIN_TEMP_P;
      5'h11:   chan_dec = SASC_AIN_GND;
      5'h12:   chan_dec = SASC_AIN_DIV3;
      default: chan_dec = SASC_AIN_NONE;
    endcase
  endfunction : chan_dec

  // Keeps the valid top bits of a left-aligned result, zeroing the rest
  function automatic logic [13:0] res_mask(input logic [3:0] bits);
    logic [13:0] m;
    m = '1;
    for (int i = 0; i < `SASC_RES_W; i++) begin
      if (i < (`SASC_RES_W - int'(bits))) begin
        m[i] = 1'b0;
      end
    end
    res_mask = m;
  endfunction : res_mask

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state

  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic        rise;
  logic        fall;
  logic        done;
  logic        tick;
  logic        start_man;
  logic        start_auto;
  logic [15:0] period;
  logic [3:0]  bits_sel;
  logic [1:0]  mode;

  always_comb begin
    d          = q;
    idx        = wb_adr_i[9:2];
    req        = wb_cyc_i & wb_stb_i;
    wr         = req & wb_we_i & q.ack & wb_sel_i[0];
    period     = {q.per_hi, q.per_lo};
    bits_sel   = res_bits(q.ressamp[`SASC_RS_RES_HI:`SASC_RS_RES_LO]);
    mode       = q.mux[`SASC_MUX_MODE_HI:`SASC_MUX_MODE_LO];
    rise       = q.vld_s & ~q.vld_p;
    fall       = ~q.vld_s & q.vld_p;
    // Codes 01 and 11 are rising; 00 is treated as rising too
    done       = (q.ctrl[`SASC_CTRL_DONE_HI:`SASC_CTRL_DONE_LO] == `SASC_DONE_FALL)
                 ? fall : rise;
    start_man  = wr & (idx == `SASC_IDX_START) & (wb_dat_i[7:0] == `SASC_START_CODE)
                 & ~q.ctrl[`SASC_CTRL_AUTO];
    start_auto = 1'b0;

    // Valid and data from the analog core are asynchronous: two stages before use
    d.vld_m  = conv_valid_i;
    d.vld_s  = q.vld_m;
    d.vld_p  = q.vld_s;
    d.cdat_m = conv_data_i;
    d.cdat_s = q.cdat_m;

    // Converter clock: half period is clkdiv+1 system clocks
    tick = 1'b0;
    if (q.div_cnt >= q.clkdiv) begin
      d.div_cnt = 8'h00;
      d.aclk    = ~q.aclk;
      tick      = ~q.aclk;
    end else begin
      d.div_cnt = q.div_cnt + 8'h01;
    end

    // Auto period; only the auxiliary slot is run, audio slots never counted
    if (q.ctrl[`SASC_CTRL_AUTO]) begin
      if ((period == 16'h0000) || (q.per_cnt >= (period - 16'h0001))) begin
        d.per_cnt  = 16'h0000;
        start_auto = 1'b1;
      end else begin
        d.per_cnt = q.per_cnt + 16'h0001;
      end
    end else begin
      d.per_cnt = 16'h0000;
    end

    // Sequence; a trigger while busy is dropped rather than queued
    case (q.fsm)
      SASC_IDLE: begin
        if (start_man | start_auto) begin
          d.fsm      = SASC_SAMPLE;
          d.samp_cnt = 8'h00;
          d.fmt      = q.mux[`SASC_MUX_FMT];
        end
      end
      SASC_SAMPLE: begin
        if (tick) begin
          if (q.samp_cnt >= (samp_len(q.ressamp[`SASC_RS_SAMP_HI:0]) - 8'h01)) begin
            d.fsm = SASC_CONVERT;
          end else begin
            d.samp_cnt = q.samp_cnt + 8'h01;
          end
        end
      end
      SASC_CONVERT: begin
        if (done) begin
          d.fsm    = SASC_IDLE;
          d.result = (q.cdat_s & res_mask(bits_sel))
                     ^ {q.fmt, 13'h0000};
        end
      end
      default: d.fsm = SASC_IDLE;
    endcase

    // Wishbone: answer one cycle after the request, drop ack the next cycle
    d.ack = req & ~q.ack;
    if (req & ~q.ack) begin
      case (idx)
        `SASC_IDX_REF:     d.dat = q.ref_sel;
        `SASC_IDX_MUX:     d.dat = q.mux;
        `SASC_IDX_MUXL:    d.dat = q.muxl;
        `SASC_IDX_MUXR:    d.dat = `SASC_RST_MUXR;
        `SASC_IDX_RESL:    d.dat = q.resl;
        `SASC_IDX_PER_LO:  d.dat = q.per_lo;
        `SASC_IDX_PER_HI:  d.dat = q.per_hi;
        `SASC_IDX_CTRL:    d.dat = q.ctrl;
        `SASC_IDX_RES_LO:  d.dat = q.result[7:0];
        `SASC_IDX_RES_HI:  d.dat = {2'b00, q.result[13:8]};
        `SASC_IDX_STATUS:  d.dat = {7'h00, q.fsm != SASC_IDLE};
        `SASC_IDX_RESSAMP: d.dat = q.ressamp;
        `SASC_IDX_BATT:    d.dat = {6'h00, q.batt};
        `SASC_IDX_CLKDIV:  d.dat = q.clkdiv;
        default:           d.dat = 8'h00;
      endcase
    end
    if (wr) begin
      case (idx)
        `SASC_IDX_REF:     d.ref_sel = wb_dat_i[7:0];
        `SASC_IDX_MUX:     d.mux     = wb_dat_i[7:0];
        `SASC_IDX_MUXL:    d.muxl    = wb_dat_i[7:0];
        `SASC_IDX_RESL:    d.resl    = wb_dat_i[7:0];
        `SASC_IDX_PER_LO:  d.per_lo  = wb_dat_i[7:0];
        `SASC_IDX_PER_HI:  d.per_hi  = wb_dat_i[7:0];
        `SASC_IDX_CTRL:    d.ctrl    = wb_dat_i[7:0];
        `SASC_IDX_RESSAMP: d.ressamp = wb_dat_i[7:0];
        `SASC_IDX_BATT:    d.batt    = wb_dat_i[1:0];
        `SASC_IDX_CLKDIV:  d.clkdiv  = wb_dat_i[7:0];
        default:           d.dat     = d.dat;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.ref_sel  <= `SASC_RST_REF;
      q.mux      <= `SASC_RST_MUX;
      q.muxl     <= `SASC_RST_MUXL;
      q.resl     <= `SASC_RST_RESL;
      q.per_lo   <= `SASC_RST_PER_LO;
      q.per_hi   <= `SASC_RST_PER_HI;
      q.ctrl     <= `SASC_RST_CTRL;
      q.ressamp  <= `SASC_RST_RESSAMP;
      q.batt     <= `SASC_RST_BATT;
      q.clkdiv   <= `SASC_RST_CLKDIV;
      q.fsm      <= SASC_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    wb_ack_o          = q.ack;
    wb_dat_o          = {24'h000000, q.dat};
    conv_clk_o        = q.aclk;
    sample_o          = (q.fsm == SASC_SAMPLE);
    busy_o            = (q.fsm != SASC_IDLE);
    analog_o.ref_sel  = q.ref_sel[1:0];
    analog_o.res_bits = bits_sel;
    analog_o.ain_pos  = chan_dec(q.mux[`SASC_MUX_CH_HI:0]);
    analog_o.ain_neg  = SASC_AIN_NONE;
    if (mode == `SASC_MODE_SINGLE) begin
      analog_o.ain_neg = SASC_AIN_GND;
    end else if (mode == `SASC_MODE_DIFF) begin
      analog_o.ain_neg = SASC_AIN_B1;
    end else begin
      // Reserved modes disconnect both inputs
      analog_o.ain_pos = SASC_AIN_NONE;
    end
    case (q.batt)
      2'h1:    analog_o.batt_div = SASC_BATT_IOSUP;
      2'h2:    analog_o.batt_div = SASC_BATT_PINB7;
      default: analog_o.batt_div = SASC_BATT_OFF;
    endcase
  end

endmodule : sasc_top

// ==== src/sasc_regs.svh ====
`ifndef SASC_REGS_SVH
`define SASC_REGS_SVH

// Register indices; the Wishbone byte address is four times the index
`define SASC_IDX_REF        8'h2b
`define SASC_IDX_MUX        8'h2c
`define SASC_IDX_MUXL       8'h2d
`define SASC_IDX_MUXR       8'h2e
`define SASC_IDX_RESL       8'h2f
`define SASC_IDX_PER_LO     8'h30
`define SASC_IDX_PER_HI     8'h31
`define SASC_IDX_CTRL       8'h33
`define SASC_IDX_START      8'h35
`define SASC_IDX_RES_LO     8'h38
`define SASC_IDX_RES_HI     8'h39
`define SASC_IDX_STATUS     8'h3a
`define SASC_IDX_RESSAMP    8'h3c
`define SASC_IDX_BATT       8'h3e
`define SASC_IDX_CLKDIV     8'h3f

// Reset values
`define SASC_RST_REF        8'h0b
`define SASC_RST_MUX        8'h02
`define SASC_RST_MUXL       8'h00
`define SASC_RST_MUXR       8'h01
`define SASC_RST_RESL       8'h01
`define SASC_RST_PER_LO     8'he0
`define SASC_RST_PER_HI     8'h00
`define SASC_RST_CTRL       8'h27
`define SASC_RST_RESSAMP    8'h00
`define SASC_RST_BATT       2'h0
`define SASC_RST_CLKDIV     8'h18

// Field positions
`define SASC_CTRL_AUTO      3
`define SASC_CTRL_DONE_HI   7
`define SASC_CTRL_DONE_LO   6
`define SASC_MUX_FMT        7
`define SASC_MUX_MODE_HI    6
`define SASC_MUX_MODE_LO    5
`define SASC_MUX_CH_HI      4
`define SASC_RS_RES_HI      5
`define SASC_RS_RES_LO      3
`define SASC_RS_SAMP_HI     2

// Codes
`define SASC_START_CODE     8'h80
`define SASC_MODE_SINGLE    2'h0
`define SASC_MODE_DIFF      2'h1
`define SASC_DONE_FALL      2'h2
`define SASC_RES_W          14

// Sampling lengths in converter clock periods
`define SASC_SAMP_0         8'h03
`define SASC_SAMP_1         8'h06
`define SASC_SAMP_2         8'h09
`define SASC_SAMP_3         8'h0c
`define SASC_SAMP_4         8'h12
`define SASC_SAMP_5         8'h18
`define SASC_SAMP_6         8'h30
`define SASC_SAMP_7         8'h90

`endif

// ==== src/sasc_pkg.sv ====
package sasc_pkg;

  typedef enum logic [1:0] {
    SASC_IDLE    = 2'b00,
    SASC_SAMPLE  = 2'b01,
    SASC_CONVERT = 2'b10
  } sasc_state_t;

  typedef enum logic [3:0] {
    SASC_AIN_NONE   = 4'b0000,
    SASC_AIN_B0     = 4'b0001,
    SASC_AIN_B1     = 4'b0010,
    SASC_AIN_B6     = 4'b0011,
    SASC_AIN_B7     = 4'b0100,
    SASC_AIN_TEMP_N = 4'b0101,
    SASC_AIN_TEMP_P = 4'b0110,
    SASC_AIN_GND    = 4'b0111,
    SASC_AIN_DIV3   = 4'b1000
  } sasc_ain_t;

  typedef enum logic [1:0] {
    SASC_BATT_OFF   = 2'b00,
    SASC_BATT_IOSUP = 2'b01,
    SASC_BATT_PINB7 = 2'b10
  } sasc_batt_t;

  // Settings presented to the analog core
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [3:0] res_bits;
    sasc_ain_t  ain_pos;
    sasc_ain_t  ain_neg;
    sasc_batt_t batt_div;
  } sasc_analog_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  dat;
    logic [7:0]  ref_sel;
    logic [7:0]  mux;
    logic [7:0]  muxl;
    logic [7:0]  resl;
    logic [7:0]  per_lo;
    logic [7:0]  per_hi;
    logic [7:0]  ctrl;
    logic [7:0]  ressamp;
    logic [1:0]  batt;
    logic [7:0]  clkdiv;
    sasc_state_t fsm;
    logic [15:0] per_cnt;
    logic [7:0]  div_cnt;
    logic        aclk;
    logic [7:0]  samp_cnt;
    logic        vld_m;
    logic        vld_s;
    logic        vld_p;
    logic [13:0] cdat_m;
    logic [13:0] cdat_s;
    logic        fmt;
    logic [13:0] result;
  } sasc_regs_t;

endpackage : sasc_pkg

// ==== sim/sasc_top_chk.sv ====
`timescale 1ns/1ps
module sasc_top_chk
  import sasc_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [9:0]   wb_adr_i,
  input wire logic [31:0]  wb_dat_i,
  input wire logic [3:0]   wb_sel_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  input wire logic         conv_valid_i,
  input wire logic [13:0]  conv_data_i,
  input wire logic         conv_clk_o,
  input wire logic         sample_o,
  input wire logic         busy_o,
  input wire sasc_analog_t analog_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  busy_cover_a: assert property (sample_o |-> busy_o)
    else $error("sampling without busy");
  start_pair_a: assert property ($rose(busy_o) |-> sample_o)
    else $error("busy rose without sampling");
  done_edge_a: assert property ($fell(busy_o) |->
    ($past(conv_valid_i, 3) != $past(conv_valid_i, 4)) && !sample_o)
    else $error("busy fell without a valid edge");
  sample_min_a: assert property ($rose(sample_o) |=> sample_o [*8])
    else $error("sampling window too short");
  res_map_a: assert property (analog_o.res_bits inside {4'h7, [4'h9:4'he]})
    else $error("resolution out of map");
  neg_map_a: assert property (analog_o.ain_neg inside {SASC_AIN_NONE, SASC_AIN_B1, SASC_AIN_GND})
    else $error("negative input illegal");

  cover property ($rose(busy_o));
  cover property ($fell(busy_o));
  cover property (wb_ack_o && wb_we_i);
endmodule : sasc_top_chk

bind sasc_top sasc_top_chk sasc_top_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .conv_valid_i,
  .conv_data_i, .conv_clk_o, .sample_o, .busy_o, .analog_o);

// ==== sim/sasc_core_model.sv ====
`timescale 1ns/1ps
module sasc_core_model (
  input  wire logic        clk_i,
  input  wire logic        sample_i,
  input  wire logic [13:0] value_i,
  output logic             valid_o,
  output logic [13:0]      data_o
);
  logic prev;

  initial begin
    valid_o = 1'b0;
    data_o  = 14'h0;
    prev    = 1'b0;
  end

  // Conversion starts when the sampling window closes
  always @(posedge clk_i) begin
    prev <= sample_i;
    if (prev && !sample_i) begin
      repeat (20) @(posedge clk_i);
      data_o <= value_i;
      @(posedge clk_i);
      valid_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      valid_o <= 1'b0;
      // Data outlives the falling edge so either done edge captures it
      repeat (4) @(posedge clk_i);
      // Stale data is scrambled so a late capture shows up
      data_o  <= ~value_i;
    end
  end
endmodule : sasc_core_model

// ==== sim/sasc_top_test.sv ====
`timescale 1ns/1ps
module sasc_top_test
  import sasc_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc   = 1'b0;
  logic         we    = 1'b0;
  logic [9:0]   adr   = 10'h0;
  logic [31:0]  dw    = 32'h0;
  logic [13:0]  val   = 14'h0;
  logic [31:0]  dr;
  logic [13:0]  cdat;
  logic         ack, vld, cclk, smp, busy;
  logic [7:0]   rv;
  sasc_analog_t an;
  int           num_errors = 0;
  int           checks = 0;
  int           tick = 0;
  time          t0;
  logic [7:0] ra [11] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h33, 8'h3c,
    8'h35, 8'h10};
  logic [7:0] rs [11] = '{8'h0b, 8'h02, 8'h00, 8'h01, 8'h01, 8'he0, 8'h00, 8'h27, 8'h00,
    8'h00, 8'h00};
  logic [3:0] rb [8] = '{4'd7, 4'd9, 4'd10, 4'd11, 4'd12, 4'd13, 4'd14, 4'd14};
  logic [7:0] ch [9] = '{8'h00, 8'h05, 8'h06, 8'h0b, 8'h0c, 8'h0f, 8'h10, 8'h11, 8'h12};

  always #2.5 clk_i = ~clk_i;

  sasc_top sasc_top_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(4'h1), .wb_dat_o(dr), .wb_ack_o(ack),
    .conv_valid_i(vld), .conv_data_i(cdat), .conv_clk_o(cclk), .sample_o(smp),
    .busy_o(busy), .analog_o(an));

  sasc_core_model sasc_core_model_i (.clk_i, .sample_i(smp), .value_i(val),
    .valid_o(vld), .data_o(cdat));

  //////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= {a, 2'b00};
    dw  <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = dr[7:0];
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conv(input logic [13:0] v, input logic [13:0] e);
    val <= v;
    bus(1, 8'h35, 8'h80);
    bus(0, 8'h3a, 8'h00);
    chk("busy", 16'h1, 16'(rv[0]));
    while (busy !== 1'b0) @(posedge clk_i);
    bus(0, 8'h38, 8'h00);
    chk("result_low", 16'(e[7:0]), 16'(rv));
    bus(0, 8'h39, 8'h00);
    chk("result_high", 16'(e[13:8]), 16'(rv));
  endtask : conv

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // Whole run needs a few thousand cycles
  always @(posedge clk_i) begin
    tick <= tick + 1;
    if (tick == 20000) begin
      num_errors++;
      close_out;
    end
  end

  //////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) begin
      bus(0, ra[i], 8'h00);
      chk("reset_value", 16'(rs[i]), 16'(rv));
    end
    bus(1, 8'h2e, 8'hff);
    bus(0, 8'h2e, 8'h00);
    chk("reserved_ro", 16'h01, 16'(rv));
    bus(1, 8'h10, 8'hff);
    bus(0, 8'h10, 8'h00);
    chk("unmapped", 16'h00, 16'(rv));
    bus(1, 8'h2d, 8'h5a);
    bus(0, 8'h2d, 8'h00);
    chk("left_input", 16'h5a, 16'(rv));
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      bus(1, 8'h3c, 8'(i << 3));
      @(posedge clk_i);
      chk("res_bits", 16'(rb[i]), 16'(an.res_bits));
    end
    for (int i = 0; i < 3; i++) begin
      bus(1, 8'h2b, 8'(i));
      @(posedge clk_i);
      chk("ref_sel", 16'(i), 16'(an.ref_sel));
    end
    foreach (ch[k]) begin
      bus(1, 8'h2c, ch[k]);
      @(posedge clk_i);
      chk("ain_pos", 16'(k), 16'(an.ain_pos));
      chk("ain_neg", 16'(SASC_AIN_GND), 16'(an.ain_neg));
    end
    bus(1, 8'h2c, 8'h25);
    @(posedge clk_i);
    chk("diff_pos", 16'(SASC_AIN_B0), 16'(an.ain_pos));
    chk("diff_neg", 16'(SASC_AIN_B1), 16'(an.ain_neg));
    for (int i = 1; i < 3; i++) begin
      bus(1, 8'h3e, 8'(i));
      @(posedge clk_i);
      chk("batt_div", 16'(i), 16'(an.batt_div));
    end
    $display("test mapping done");
    bus(1, 8'h33, 8'h40);
    bus(1, 8'h2b, 8'h00);
    bus(1, 8'h2c, 8'h12);
    bus(1, 8'h3c, 8'h30);
    conv(14'h2a5c, 14'h2a5c);
    bus(1, 8'h2c, 8'h92);
    conv(14'h2a5c, 14'h0a5c);
    bus(1, 8'h3c, 8'h20);
    conv(14'h1fff, 14'h3ffc);
    bus(1, 8'h33, 8'h80);
    conv(14'h1555, 14'h3554);
    @(posedge cclk);
    t0 = $time;
    @(posedge cclk);
    chk("conv_clk", 16'h0032, 16'(($time - t0) / 5));
    $display("test manual done");
    bus(1, 8'h30, 8'h00);
    bus(1, 8'h31, 8'h04);
    bus(1, 8'h33, 8'h48);
    @(posedge busy);
    t0 = $time;
    @(posedge busy);
    chk("auto_period", 16'd1024, 16'(($time - t0) / 5));
    bus(1, 8'h33, 8'h40);
    while (busy !== 1'b0) @(posedge clk_i);
    $display("test auto done");
    close_out;
  end
endmodule : sasc_top_test
